// File: design/uit_core.sv
// status flags, receive time-out counter, tx gap and baud divider of the uart
`timescale 1ns/10ps
module uit_core (
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire uit_pkg::uit_apb_req_t apb_req,
   output uit_pkg::uit_apb_rsp_t      apb_rsp,
   input  wire uit_pkg::uit_src_t     src,
   output uit_pkg::uit_ctl_t          ctl
);
   import uit_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // prescale terminal count: 16 in mode 0, extra divider + 1 in mode 1, 1 in mode 2
   function automatic logic [3:0] prescale_top(input logic [1:0] mode, input logic [3:0] ediv);
      logic [3:0] top;
      top = `UIT_M0_PRESCALE;
      case (mode)
         `UIT_BM_1: top = ediv;
         `UIT_BM_2: top = 4'h0;
         default:   top = `UIT_M0_PRESCALE;
      endcase
      return top;
   endfunction : prescale_top

   function automatic logic addr_hit(input logic [`UIT_ADDR_W-1:0] a, input logic [`UIT_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction : addr_hit

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   uit_state_t s_reg;
   uit_state_t s_next;

   logic        lin_any;
   logic        wake_any;
   logic        buf_err;
   logic        modem_flag;
   logic        rls_flag;
   logic        rda_flag;
   logic        rs485;
   logic [7:0]  flags;
   logic [7:0]  ind;
   logic [31:0] intsts;
   logic        acc;
   logic        commit_wr;
   logic        hit_inten;
   logic        hit_intsts;
   logic        hit_tout;
   logic        hit_baud;
   logic        hit_fsel;
   logic        mapped;
   logic        div_end;
   logic        pre_end;
   logic        to_match;
   logic        rxto_clr;
   logic [31:0] rdata;

   // ---------------------------------------------------------------
   // flag merge
   // ---------------------------------------------------------------
   always_comb begin
      rs485      = s_reg.function_selector == `UIT_FN_RS485;
      lin_any    = src.slave_header_found | src.lin_break_found | src.lin_bit_error
                   | src.slave_id_parity_error | src.slave_header_error;
      wake_any   = src.timeout_wake_flag | src.multidrop_wake_flag | src.fifo_threshold_wake_flag
                   | src.data_wake_flag | src.cts_line_wake_flag;
      buf_err    = src.tx_overflow_flag | src.rx_overflow_flag;
      modem_flag = src.clear_to_send_change_flag;
      rls_flag   = src.break_flag | src.framing_error_flag | src.parity_error_flag
                   | (rs485 & src.address_byte_flag);
      // a trigger level of zero would fire on an empty fifo, so one word is required
      rda_flag   = (src.rx_count >= {1'b0, src.rx_trigger_level})
                   && (src.rx_count != 5'h00);
      flags      = {s_reg.lin_event_flag, wake_any, buf_err, s_reg.rx_timeout_flag,
                    modem_flag, rls_flag, s_reg.tx_holding_empty_flag, rda_flag};
      ind        = flags & {s_reg.int_enable[`UIT_EN_LIN], s_reg.int_enable[`UIT_EN_WK:`UIT_EN_RDA]};
      intsts     = {16'h0000, ind, flags};
   end

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   always_comb begin
      hit_inten  = addr_hit(apb_req.paddr, `UIT_OFS_INTEN);
      hit_intsts = addr_hit(apb_req.paddr, `UIT_OFS_INTSTS);
      hit_tout   = addr_hit(apb_req.paddr, `UIT_OFS_TOUT);
      hit_baud   = addr_hit(apb_req.paddr, `UIT_OFS_BAUD);
      hit_fsel   = addr_hit(apb_req.paddr, `UIT_OFS_FNSEL);
      mapped     = hit_inten | hit_intsts | hit_tout | hit_baud | hit_fsel;
      acc        = apb_req.psel & apb_req.penable;
      // writes land on the edge where pready is seen high, never earlier
      commit_wr  = acc & s_reg.pready & apb_req.pwrite & mapped;
      rdata      = 32'h00000000;
      if (hit_inten) begin
         rdata[11:0] = s_reg.int_enable;
      end else if (hit_intsts) begin
         rdata = intsts;
      end else if (hit_tout) begin
         rdata[15:0] = {s_reg.tx_gap_bit_times, s_reg.timeout_compare_value};
      end else if (hit_baud) begin
         rdata = {2'b00, s_reg.baud_mode, s_reg.extra_divider_mode1, 8'h00, s_reg.baud_divisor};
      end else if (hit_fsel) begin
         rdata[2:0] = s_reg.function_selector;
      end
   end

   // ---------------------------------------------------------------
   // baud tick and time-out compare
   // ---------------------------------------------------------------
   always_comb begin
      // bit period is (divisor + 2) clocks times the prescale of the mode
      div_end  = {1'b0, s_reg.div_cnt} == ({1'b0, s_reg.baud_divisor} + 17'h00001);
      pre_end  = s_reg.pre_cnt == prescale_top(s_reg.baud_mode, s_reg.extra_divider_mode1);
      // the flag fires on the tick that brings the count onto the comparator
      to_match = s_reg.int_enable[`UIT_EN_TOCNT] && s_reg.baud_tick && !src.rx_word_in
                 && (s_reg.to_cnt != `UIT_TO_MAX)
                 && ((s_reg.to_cnt + 8'h01) == s_reg.timeout_compare_value)
                 && !src.rx_fifo_empty;
      rxto_clr = src.rx_word_in | src.rx_fifo_empty | src.rx_data_read;
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_next = s_reg;

      // apb: one wait state so read data comes from a flop
      s_next.pready  = acc & !s_reg.pready;
      s_next.pslverr = acc & !s_reg.pready & !mapped;
      if (acc && !s_reg.pready) begin
         s_next.prdata = apb_req.pwrite ? 32'h00000000 : rdata;
      end

      if (commit_wr && hit_inten) begin
         s_next.int_enable = apb_req.pwdata[11:0];
      end
      if (commit_wr && hit_tout) begin
         s_next.timeout_compare_value = apb_req.pwdata[`UIT_CMP_LSB +: 8];
         s_next.tx_gap_bit_times      = apb_req.pwdata[`UIT_GAP_LSB +: 8];
      end
      if (commit_wr && hit_baud) begin
         s_next.baud_divisor        = apb_req.pwdata[`UIT_DIV_LSB +: 16];
         s_next.extra_divider_mode1 = apb_req.pwdata[`UIT_EDIV_LSB +: 4];
         s_next.baud_mode           = apb_req.pwdata[`UIT_BMODE_LSB +: 2];
      end
      if (commit_wr && hit_fsel) begin
         s_next.function_selector = apb_req.pwdata[2:0];
      end

      // lin flag: write one clears only once every source is clear; a source wins
      if (commit_wr && hit_intsts && apb_req.pwdata[`UIT_ST_LIN] && !lin_any) begin
         s_next.lin_event_flag = 1'b0;
      end
      if (lin_any) begin
         s_next.lin_event_flag = 1'b1;
      end

      // holding empty: the move of the last byte wins over a same-cycle write
      if (src.tx_data_write) begin
         s_next.tx_holding_empty_flag = 1'b0;
      end
      if (src.tx_last_moved) begin
         s_next.tx_holding_empty_flag = 1'b1;
      end

      // baud generator; a divider write restarts it so the new rate starts cleanly
      s_next.baud_tick = 1'b0;
      if (commit_wr && hit_baud) begin
         s_next.div_cnt = 16'h0000;
         s_next.pre_cnt = 4'h0;
      end else if (div_end) begin
         s_next.div_cnt = 16'h0000;
         if (pre_end) begin
            s_next.pre_cnt   = 4'h0;
            s_next.baud_tick = 1'b1;
         end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 4'h1;
         end
      end else begin
         s_next.div_cnt = s_reg.div_cnt + 16'h0001;
      end

      // time-out counter saturates so it never wraps onto the comparator again
      if (!s_reg.int_enable[`UIT_EN_TOCNT] || src.rx_word_in) begin
         s_next.to_cnt = 8'h00;
      end else if (s_reg.baud_tick && s_reg.to_cnt != `UIT_TO_MAX) begin
         s_next.to_cnt = s_reg.to_cnt + 8'h01;
      end
      if (rxto_clr) begin
         s_next.rx_timeout_flag = 1'b0;
      end
      if (to_match) begin
         s_next.rx_timeout_flag = 1'b1;
      end

      // gap between last stop bit and next start bit, counted in bit ticks
      case (s_reg.gap_state)
         GAP_IDLE: begin
            if (src.tx_stop_done && s_reg.tx_gap_bit_times != 8'h00) begin
               s_next.gap_cnt   = s_reg.tx_gap_bit_times;
               s_next.gap_state = GAP_WAIT;
            end
         end
         GAP_WAIT: begin
            if (s_reg.baud_tick) begin
               s_next.gap_cnt = s_reg.gap_cnt - 8'h01;
               if (s_reg.gap_cnt == 8'h01) begin
                  s_next.gap_state = GAP_IDLE;
               end
            end
         end
         default: begin
            s_next.gap_state = GAP_IDLE;
            s_next.gap_cnt   = 8'h00;
         end
      endcase

      s_next.irq_ind = ind;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         s_reg.tx_gap_bit_times      <= 8'(`UIT_RST_TOUT >> `UIT_GAP_LSB);
         s_reg.timeout_compare_value <= 8'(`UIT_RST_TOUT >> `UIT_CMP_LSB);
         s_reg.baud_mode             <= 2'(`UIT_RST_BAUD >> `UIT_BMODE_LSB);
         s_reg.extra_divider_mode1   <= 4'(`UIT_RST_BAUD >> `UIT_EDIV_LSB);
         s_reg.baud_divisor          <= 16'(`UIT_RST_BAUD >> `UIT_DIV_LSB);
         s_reg.int_enable            <= `UIT_RST_INTEN;
         s_reg.function_selector     <= `UIT_RST_FNSEL;
         s_reg.lin_event_flag        <= 1'b0;
         s_reg.tx_holding_empty_flag <= 1'b1;
         s_reg.rx_timeout_flag       <= 1'b0;
         s_reg.to_cnt                <= 8'h00;
         s_reg.pre_cnt               <= 4'h0;
         s_reg.div_cnt               <= 16'h0000;
         s_reg.baud_tick             <= 1'b0;
         s_reg.gap_state             <= GAP_IDLE;
         s_reg.gap_cnt               <= 8'h00;
         s_reg.irq_ind               <= 8'h00;
         s_reg.prdata                <= 32'h00000000;
         s_reg.pready                <= 1'b0;
         s_reg.pslverr               <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb begin
      apb_rsp.prdata        = s_reg.prdata;
      apb_rsp.pready        = s_reg.pready;
      apb_rsp.pslverr       = s_reg.pslverr;
      ctl.baud_tick         = s_reg.baud_tick;
      ctl.tx_start_ok       = s_reg.gap_state == GAP_IDLE;
      ctl.function_selector = s_reg.function_selector;
      ctl.irq_indicators    = s_reg.irq_ind;
   end

endmodule : uit_core

// File: design/uit_params.svh
// constants of the uart status, receive time-out and baud divider block
`ifndef UIT_PARAMS_SVH
`define UIT_PARAMS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define UIT_ADDR_W        12
`define UIT_OFS_INTEN     12'h004
`define UIT_OFS_INTSTS    12'h01C
`define UIT_OFS_TOUT      12'h020
`define UIT_OFS_BAUD      12'h024
`define UIT_OFS_FNSEL     12'h030

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define UIT_RST_TOUT      32'h00000000
`define UIT_RST_BAUD      32'h0F000000
`define UIT_RST_INTEN     12'h000
`define UIT_RST_FNSEL     3'h0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UIT_CMP_LSB       0
`define UIT_GAP_LSB       8
`define UIT_DIV_LSB       0
`define UIT_EDIV_LSB      24
`define UIT_BMODE_LSB     28
`define UIT_EN_RDA        0
`define UIT_EN_THRE       1
`define UIT_EN_RLS        2
`define UIT_EN_MODEM      3
`define UIT_EN_RXTO       4
`define UIT_EN_BUFERR     5
`define UIT_EN_WK         6
`define UIT_EN_LIN        8
`define UIT_EN_TOCNT      11
`define UIT_ST_LIN        7
`define UIT_IND_LSB       8

// ---------------------------------------------------------------
// mode codes and counts
// ---------------------------------------------------------------
`define UIT_FN_UART       3'h0
`define UIT_FN_LIN        3'h1
`define UIT_FN_IRDA       3'h2
`define UIT_FN_RS485      3'h3
`define UIT_BM_0          2'h0
`define UIT_BM_1          2'h2
`define UIT_BM_2          2'h3
`define UIT_M0_PRESCALE   4'hF
`define UIT_TO_MAX        8'hFF

`endif

// File: design/uit_pkg.sv
// types of the uart status, receive time-out and baud divider block
`include "uit_params.svh"
package uit_pkg;

   typedef struct packed {
      logic                     psel;
      logic                     penable;
      logic                     pwrite;
      logic [`UIT_ADDR_W-1:0]   paddr;
      logic [31:0]              pwdata;
   } uit_apb_req_t;

   typedef struct packed {
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
   } uit_apb_rsp_t;

   // flags and strobes from the rest of the uart, all on the same clock
   typedef struct packed {
      logic                     rx_fifo_empty;
      logic                     rx_word_in;
      logic                     rx_data_read;
      logic [4:0]               rx_count;
      logic [3:0]               rx_trigger_level;
      logic                     tx_last_moved;
      logic                     tx_data_write;
      logic                     tx_stop_done;
      logic                     break_flag;
      logic                     framing_error_flag;
      logic                     parity_error_flag;
      logic                     address_byte_flag;
      logic                     clear_to_send_change_flag;
      logic                     tx_overflow_flag;
      logic                     rx_overflow_flag;
      logic                     slave_header_found;
      logic                     lin_break_found;
      logic                     lin_bit_error;
      logic                     slave_id_parity_error;
      logic                     slave_header_error;
      logic                     timeout_wake_flag;
      logic                     multidrop_wake_flag;
      logic                     fifo_threshold_wake_flag;
      logic                     data_wake_flag;
      logic                     cts_line_wake_flag;
   } uit_src_t;

   typedef struct packed {
      logic                     baud_tick;
      logic                     tx_start_ok;
      logic [2:0]               function_selector;
      logic [7:0]               irq_indicators;
   } uit_ctl_t;

   typedef enum logic [1:0] {
      GAP_IDLE = 2'b01,
      GAP_WAIT = 2'b10
   } uit_gap_state_t;

   typedef struct packed {
      logic [7:0]               tx_gap_bit_times;
      logic [7:0]               timeout_compare_value;
      logic [1:0]               baud_mode;
      logic [3:0]               extra_divider_mode1;
      logic [15:0]              baud_divisor;
      logic [11:0]              int_enable;
      logic [2:0]               function_selector;
      logic                     lin_event_flag;
      logic                     tx_holding_empty_flag;
      logic                     rx_timeout_flag;
      logic [7:0]               to_cnt;
      logic [3:0]               pre_cnt;
      logic [15:0]              div_cnt;
      logic                     baud_tick;
      uit_gap_state_t           gap_state;
      logic [7:0]               gap_cnt;
      logic [7:0]               irq_ind;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
   } uit_state_t;

endpackage : uit_pkg

// File: bench/uit_core_chk.sv
// port checks of the uart status, time-out and baud block
`timescale 1ns/10ps
`include "uit_params.svh"
module uit_core_chk (
   input wire logic                  clock,
   input wire logic                  rst,
   input wire uit_pkg::uit_apb_req_t apb_req,
   input wire uit_pkg::uit_apb_rsp_t apb_rsp,
   input wire uit_pkg::uit_src_t     src,
   input wire uit_pkg::uit_ctl_t     ctl
);
   import uit_pkg::*;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // indicators lag the status byte by a clock, so causes are looked up one cycle back
   apb_one_wait_a: assert property ($rose(apb_req.psel && apb_req.penable) |->
      !apb_rsp.pready ##1 apb_rsp.pready ##1 !apb_rsp.pready) else $error("ready not after one wait state");
   err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("error without ready");
   buf_err_ind_a: assert property (!$past(src.tx_overflow_flag || src.rx_overflow_flag) |->
      !ctl.irq_indicators[5]) else $error("buffer error indicator without overflow");
   wake_ind_a: assert property (!$past(src.timeout_wake_flag || src.multidrop_wake_flag ||
      src.fifo_threshold_wake_flag || src.data_wake_flag || src.cts_line_wake_flag) |->
      !ctl.irq_indicators[6]) else $error("wake indicator without source");
   modem_ind_a: assert property (!$past(src.clear_to_send_change_flag) |-> !ctl.irq_indicators[3])
      else $error("modem indicator without change flag");
   line_ind_a: assert property (!$past(src.break_flag || src.framing_error_flag ||
      src.parity_error_flag || src.address_byte_flag) |-> !ctl.irq_indicators[2])
      else $error("line status indicator without error");
   rda_ind_a: assert property ($past(src.rx_count < {1'b0, src.rx_trigger_level} || src.rx_count == 5'h00)
      |-> !ctl.irq_indicators[0]) else $error("data available below level");
   rxto_clear_a: assert property (src.rx_word_in || src.rx_fifo_empty |-> ##2 !ctl.irq_indicators[4])
      else $error("time-out indicator survives word or empty fifo");
   gap_cause_a: assert property ($fell(ctl.tx_start_ok) |-> $past(src.tx_stop_done))
      else $error("start blocked without stop bit");
   fsel_write_a: assert property (!(apb_rsp.pready && apb_req.pwrite &&
      apb_req.paddr == `UIT_OFS_FNSEL) |=> $stable(ctl.function_selector)) else $error("selector changed");
   tick_pulse_a: assert property (ctl.baud_tick |=> !ctl.baud_tick) else $error("bit tick too long");
endmodule : uit_core_chk
bind uit_core uit_core_chk chk_i (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .src(src), .ctl(ctl));

// File: bench/uit_station.sv
// remote station model: sends characters into the receive fifo, which software drains
`timescale 1ns/10ps
module uit_station (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       baud_tick,
   input  wire logic       send,
   input  wire logic       take,
   output logic            word_in,
   output logic [4:0]      rx_count
);
   int bits_left;
   // a character is ten bit times on the line; a read of an empty fifo is dropped
   always @(posedge clock) begin
      word_in <= 1'b0;
      if (rst) begin
         bits_left <= 0;
         rx_count  <= 5'h00;
      end else begin
         if (send && bits_left == 0) begin
            bits_left <= 10;
         end else if (baud_tick && bits_left > 0) begin
            bits_left <= bits_left - 1;
            word_in   <= (bits_left == 1);
         end
         rx_count <= rx_count + {4'h0, word_in} - {4'h0, take && rx_count != 5'h00};
      end
   end
endmodule : uit_station

// File: bench/uart_irq_timeout_baud_tb_top.sv
// self-checking bench of the uart status, time-out and baud block
`timescale 1ns/10ps
`include "uit_params.svh"
module uart_irq_timeout_baud_tb_top;
   import uit_pkg::*;
   localparam logic [11:0] A_EN = `UIT_OFS_INTEN;
   localparam logic [11:0] A_ST = `UIT_OFS_INTSTS;
   localparam logic [11:0] A_TO = `UIT_OFS_TOUT;
   localparam logic [11:0] A_BD = `UIT_OFS_BAUD;
   localparam logic [11:0] A_FN = `UIT_OFS_FNSEL;
   logic          clock = 1'b0;
   logic          rst   = 1'b1;
   uit_apb_req_t  req   = '0;
   uit_apb_rsp_t  rsp;
   uit_src_t      flg   = '0;
   uit_src_t      src;
   uit_ctl_t      ctl;
   logic          send  = 1'b0;
   logic          take  = 1'b0;
   logic          word_in;
   logic [4:0]    rx_count;
   logic [33:0]   exp_q[$];
   logic [33:0]   e;
   int            fail_count = 0;
   int            samples_checked = 0;
   int            cycles = 0;
   int            seed = 67;
   always_comb begin
      src               = flg;
      src.rx_word_in    = word_in;
      src.rx_count      = rx_count;
      src.rx_fifo_empty = (rx_count == 5'h00);
      src.rx_data_read  = take;
   end
   uit_core dut (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .src(src), .ctl(ctl));
   uit_station stn (.clock(clock), .rst(rst), .baud_tick(ctl.baud_tick), .send(send), .take(take),
      .word_in(word_in), .rx_count(rx_count));
   initial begin
      forever #12.5 clock = ~clock;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ex,
                      input logic err);
      exp_q.push_back({!wr, err, ex});
      @(posedge clock);
      req.psel    <= 1'b1;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge clock);
      req.penable <= 1'b1;
      // no limit of its own: pready or the bench timeout ends this wait
      do begin
         @(posedge clock);
      end while (rsp.pready !== 1'b1);
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0, ex, 1'b0);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr
   task automatic word;
      @(posedge clock) send <= 1'b1;
      @(posedge clock) send <= 1'b0;
      while (word_in !== 1'b1) begin
         @(posedge clock);
      end
   endtask : word
   task automatic read_data;
      @(posedge clock) take <= 1'b1;
      @(posedge clock) take <= 1'b0;
   endtask : read_data
   // responses are matched in order against what the driver noted
   always @(posedge clock) begin
      if (rsp.pready === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("slave error", {31'h0, rsp.pslverr}, {31'h0, e[32]});
         if (e[33]) check("read data", rsp.prdata, e[31:0]);
      end
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      int          n;
      logic [31:0] v;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(A_TO, 32'h0);
      rd(A_BD, 32'h0F000000);
      rd(A_EN, 32'h0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         wr(A_TO, v);
         rd(A_TO, v & 32'h0000FFFF);
         wr(A_BD, v);
         rd(A_BD, v & 32'h3F00FFFF);
      end
      for (int f = 0; f < 6; f++) begin
         wr(A_FN, f);
         rd(A_FN, f);
         check("selector pins", ctl.function_selector, f);
      end
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         // infrared only together with baud mode 0
         wr(A_FN, (m == 0) ? 32'h2 : 32'h0);
         wr(A_BD, {2'b00, m[1:0], 4'h3, 8'h00, 16'h0002});
         // skip the restart edge, where a tick of the old rate may still show
         @(posedge clock);
         n = 0;
         while (ctl.baud_tick !== 1'b1 && n < 500) @(posedge clock) n++;
         n = 0;
         do @(posedge clock) n++; while (ctl.baud_tick !== 1'b1 && n < 500);
         check("baud period", n, 4 * (m < 2 ? 16 : m == 2 ? 4 : 1));
      end
      $display("test baud done");
      wr(A_FN, 32'h0);
      wr(A_BD, 32'h30000000);
      wr(A_TO, 32'hFF);
      wr(A_EN, 32'h97F);
      flg.rx_trigger_level <= 4'hF;
      rd(A_ST, 32'h0202);
      @(posedge clock) flg.tx_data_write <= 1'b1;
      @(posedge clock) flg.tx_data_write <= 1'b0;
      rd(A_ST, 32'h0);
      // bit i of the source struct is one of the seventeen status sources, break at the top; only the lin ones are sticky
      for (int i = 0; i < 17; i++) begin
         v = i < 5 ? 32'h4040 : i < 10 ? 32'h8080 : i < 12 ? 32'h2020 : i == 12 ? 32'h0808 : i == 13 ? 0 : 32'h0404;
         @(posedge clock) flg <= uit_src_t'(flg | (32'h1 << i));
         rd(A_ST, v);
         check("indicator pins", ctl.irq_indicators, v[15:8]);
         wr(A_ST, 32'h80);
         rd(A_ST, v);
         @(posedge clock) flg <= uit_src_t'(flg & ~(32'h1 << i));
         rd(A_ST, v & 32'h8080);
         wr(A_ST, 32'h80);
         rd(A_ST, 32'h0);
      end
      wr(A_FN, 32'h3);
      @(posedge clock) flg.address_byte_flag <= 1'b1;
      rd(A_ST, 32'h0404);
      wr(A_EN, 32'h0);
      rd(A_ST, 32'h0004);
      @(posedge clock) flg.address_byte_flag <= 1'b0;
      rd(A_ST, 32'h0);
      wr(A_FN, 32'h0);
      wr(A_EN, 32'h97F);
      @(posedge clock) flg.tx_last_moved <= 1'b1;
      @(posedge clock) flg.tx_last_moved <= 1'b0;
      rd(A_ST, 32'h0202);
      @(posedge clock) flg.tx_data_write <= 1'b1;
      @(posedge clock) flg.tx_data_write <= 1'b0;
      $display("test flags done");
      flg.rx_trigger_level <= 4'h2;
      word();
      rd(A_ST, 32'h0);
      word();
      rd(A_ST, 32'h0101);
      read_data();
      rd(A_ST, 32'h0);
      flg.rx_trigger_level <= 4'hF;
      wr(A_TO, 32'h28);
      word();
      repeat (50) @(posedge clock);
      rd(A_ST, 32'h0);
      repeat (60) @(posedge clock);
      rd(A_ST, 32'h1010);
      read_data();
      rd(A_ST, 32'h0);
      repeat (120) @(posedge clock);
      rd(A_ST, 32'h0);
      word();
      repeat (120) @(posedge clock);
      rd(A_ST, 32'h1010);
      word();
      rd(A_ST, 32'h0);
      repeat (3) read_data();
      $display("test time-out done");
      wr(A_TO, 32'h0300);
      @(posedge clock) flg.tx_stop_done <= 1'b1;
      @(posedge clock) flg.tx_stop_done <= 1'b0;
      #1;
      check("gap start", ctl.tx_start_ok, 1'b0);
      n = 0;
      for (int k = 0; k < 200 && ctl.tx_start_ok !== 1'b1; k++) begin
         @(posedge clock);
         n += (ctl.baud_tick === 1'b1);
         #1;
      end
      check("gap ticks", n, 3);
      $display("test gap done");
      wrap_up();
   end
endmodule : uart_irq_timeout_baud_tb_top
